// >>> src/acc_pkg.sv
package acc_pkg;

  // ==================================================================
  // register byte offsets on the ahb-lite slave
  localparam logic [7:0] ACC_CMP_CS_OFF = 8'h00;
  localparam logic [7:0] ACC_SFR_OFF = 8'h04;
  localparam logic [7:0] ACC_CONV_CS_OFF = 8'h08;
  localparam logic [7:0] ACC_CHAN_OFF = 8'h0c;
  localparam logic [7:0] ACC_RES_LO_OFF = 8'h10;
  localparam logic [7:0] ACC_RES_HI_OFF = 8'h14;
  localparam logic [7:0] ACC_GIE_OFF = 8'h18;

  // ==================================================================
  // comparator control/status field positions
  localparam int ACC_CMP_OUT_BIT = 5;
  localparam int ACC_CMP_FLAG_BIT = 4;
  localparam int ACC_CMP_IE_BIT = 3;
  localparam int ACC_CMP_CAP_BIT = 2;
  localparam int ACC_CMP_MODE_HI_BIT = 1;
  localparam int ACC_CMP_MODE_LO_BIT = 0;
  // special function register
  localparam int ACC_SFR_MUXEN_BIT = 3;
  // converter control/status
  localparam int ACC_CONV_EN_BIT = 7;
  localparam int ACC_CONV_START_BIT = 6;
  localparam int ACC_CONV_FREE_BIT = 5;
  localparam int ACC_CONV_DONE_BIT = 4;
  localparam int ACC_CONV_DIE_BIT = 3;
  // channel select register
  localparam int ACC_REF_HI_BIT = 7;
  localparam int ACC_REF_LO_BIT = 6;
  localparam int ACC_LADJ_BIT = 5;
  localparam int ACC_CH_HI_BIT = 4;

  // ==================================================================
  // comparator interrupt modes
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'b00,
    ACC_MODE_RSVD = 2'b01,
    ACC_MODE_FALL = 2'b10,
    ACC_MODE_RISE = 2'b11
  } acc_mode_type;

  // converter sequencer states
  typedef enum logic [1:0] {
    ACC_ST_OFF = 2'b00,
    ACC_ST_IDLE = 2'b01,
    ACC_ST_CONV = 2'b10
  } acc_state_type;

  // ==================================================================
  // conversion timing, in converter clock cycles and system cycles per converter cycle
  localparam int ACC_NORMAL_CYCLES = 13;
  localparam int ACC_FIRST_CYCLES = 25;
  localparam int ACC_CONV_CLK_DIV = 4;
  localparam logic [7:0] ACC_NORMAL_COUNT = 8'(ACC_NORMAL_CYCLES * ACC_CONV_CLK_DIV);
  localparam logic [7:0] ACC_FIRST_COUNT = 8'(ACC_FIRST_CYCLES * ACC_CONV_CLK_DIV);
  localparam logic [7:0] ACC_CMP_MUX_DIS = 8'h08;

endpackage

// >>> src/acc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - comparator irq needs enable and global enable
// - capture route gates comparator to timer
// - mode field picks toggle, fall or rise
// - mux enable with converter off picks pin
// - ten-bit result code from converter core
// - reference select: external, supply, internal
// - channel bits pick input and gain
// - eight single, sixteen differential selections
// - selections inactive until converter enabled
// - right justified default, left on adjust
// - read low byte before high byte
// - low read locks, high read unlocks
// - locked completion discards result
// - done flag set even when discarded
// - start bit high during conversion
// - channel change applies after conversion
// - free running still needs first start
// - free running ignores done flag state
// - comparator flag set, vector or w1 clear
// - comparator output synchronised two flops
// - conversion 13 cycles, first 25
// - completion writes data, sets flag
module acc_ctrl (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // comparator front end
  input wire logic cmp_raw,
  input wire logic cmp_irq_ack,
  output logic cmp_irq,
  output logic cmp_capture_out,
  output logic [3:0] cmp_neg_select,
  // converter analog core
  input wire logic [9:0] core_result,
  input wire logic conv_irq_ack,
  output logic conv_irq,
  output logic [1:0] reference_select,
  output logic [4:0] channel_active,
  output logic core_enable,
  output logic core_sample
);
  import acc_pkg::*;

  // ==================================================================
  // bus front end
  logic ph_valid;
  logic ph_write;
  logic [7:0] ph_addr;
  logic bus_rd;
  logic bus_wr;
  logic [31:0] next_rdata;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 8'h00;
    end else if (hready) begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr <= haddr;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign bus_wr = ph_valid && ph_write;
  assign bus_rd = hsel && htrans[1] && !hwrite && hready;

  function automatic logic wr_to(input logic [7:0] off, input logic [7:0] a, input logic w);
    return w && (a == off);
  endfunction

  // ==================================================================
  // registers
  logic cmp_ie;
  logic cmp_cap;
  acc_mode_type cmp_mode;
  logic cmp_flag;
  logic mux_en;
  logic gie;
  logic conv_en;
  logic start;
  logic free_run;
  logic done_flag;
  logic done_ie;
  logic [7:0] chan_reg;
  logic [15:0] result;
  logic locked;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_ie <= 1'b0;
      cmp_cap <= 1'b0;
      cmp_mode <= ACC_MODE_TOGGLE;
      mux_en <= 1'b0;
      gie <= 1'b0;
      chan_reg <= 8'h00;
    end else begin
      if (wr_to(ACC_CMP_CS_OFF, ph_addr, bus_wr)) begin
        cmp_ie <= hwdata[ACC_CMP_IE_BIT];
        cmp_cap <= hwdata[ACC_CMP_CAP_BIT];
        cmp_mode <= acc_mode_type'({hwdata[ACC_CMP_MODE_HI_BIT], hwdata[ACC_CMP_MODE_LO_BIT]});
      end
      if (wr_to(ACC_SFR_OFF, ph_addr, bus_wr)) begin
        mux_en <= hwdata[ACC_SFR_MUXEN_BIT];
      end
      if (wr_to(ACC_GIE_OFF, ph_addr, bus_wr)) begin
        gie <= hwdata[0];
      end
      if (wr_to(ACC_CHAN_OFF, ph_addr, bus_wr)) begin
        chan_reg <= hwdata[7:0];
      end
    end
  end

  // ==================================================================
  // comparator
  logic cmp_s1;
  logic cmp_s2;
  logic cmp_prev;
  logic cmp_event;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_s1 <= 1'b0;
      cmp_s2 <= 1'b0;
      cmp_prev <= 1'b0;
    end else begin
      cmp_s1 <= cmp_raw;
      cmp_s2 <= cmp_s1;
      cmp_prev <= cmp_s2;
    end
  end

  always_comb begin
    unique case (cmp_mode)
      ACC_MODE_TOGGLE: cmp_event = cmp_s2 ^ cmp_prev;
      ACC_MODE_FALL: cmp_event = cmp_prev && !cmp_s2;
      ACC_MODE_RISE: cmp_event = !cmp_prev && cmp_s2;
      ACC_MODE_RSVD: cmp_event = 1'b0;
    endcase
  end

  // set wins over both clear paths
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_flag <= 1'b0;
    end else if (cmp_event) begin
      cmp_flag <= 1'b1;
    end else if (cmp_irq_ack ||
                 (wr_to(ACC_CMP_CS_OFF, ph_addr, bus_wr) && hwdata[ACC_CMP_FLAG_BIT])) begin
      cmp_flag <= 1'b0;
    end
  end

  assign cmp_irq = cmp_flag && cmp_ie && gie;
  assign cmp_capture_out = cmp_cap && cmp_s2;
  assign cmp_neg_select = (mux_en && !conv_en) ? {1'b0, chan_reg[2:0]} : ACC_CMP_MUX_DIS[3:0];

  // ==================================================================
  // converter sequencer
  acc_state_type state;
  logic [7:0] count;
  logic first_conv;
  logic [7:0] chan_latched;
  logic complete;

  assign complete = (state == ACC_ST_CONV) && (count == 8'h01);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ACC_ST_OFF;
      count <= 8'h00;
      first_conv <= 1'b1;
    end else if (!conv_en) begin
      state <= ACC_ST_OFF;
      count <= 8'h00;
      first_conv <= 1'b1;
    end else begin
      unique case (state)
        ACC_ST_OFF: state <= ACC_ST_IDLE;
        ACC_ST_IDLE: begin
          if (start) begin
            state <= ACC_ST_CONV;
            count <= first_conv ? ACC_FIRST_COUNT : ACC_NORMAL_COUNT;
          end
        end
        ACC_ST_CONV: begin
          if (complete) begin
            first_conv <= 1'b0;
            if (free_run) begin
              count <= ACC_NORMAL_COUNT;
            end else begin
              state <= ACC_ST_IDLE;
            end
          end else begin
            count <= count - 8'h01;
          end
        end
        default: state <= ACC_ST_OFF;
      endcase
    end
  end

  // selections track freely except while a conversion holds them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      chan_latched <= 8'h00;
    end else if (state != ACC_ST_CONV || complete) begin
      chan_latched <= chan_reg;
    end
  end

  assign core_enable = conv_en;
  assign reference_select = conv_en ? chan_latched[ACC_REF_HI_BIT:ACC_REF_LO_BIT] : 2'b00;
  assign channel_active = conv_en ? chan_latched[ACC_CH_HI_BIT:0] : 5'h00;
  assign core_sample = complete;

  // converter control/status
  logic conv_cs_wr;
  assign conv_cs_wr = wr_to(ACC_CONV_CS_OFF, ph_addr, bus_wr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conv_en <= 1'b0;
      free_run <= 1'b0;
      done_ie <= 1'b0;
    end else if (conv_cs_wr) begin
      conv_en <= hwdata[ACC_CONV_EN_BIT];
      free_run <= hwdata[ACC_CONV_FREE_BIT];
      done_ie <= hwdata[ACC_CONV_DIE_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start <= 1'b0;
    end else if (!conv_en && !(conv_cs_wr && hwdata[ACC_CONV_EN_BIT])) begin
      start <= 1'b0;
    end else if (conv_cs_wr && hwdata[ACC_CONV_START_BIT]) begin
      start <= 1'b1;
    end else if (complete && !free_run) begin
      start <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_flag <= 1'b0;
    end else if (complete) begin
      done_flag <= 1'b1;
    end else if (conv_irq_ack || (conv_cs_wr && hwdata[ACC_CONV_DONE_BIT])) begin
      done_flag <= 1'b0;
    end
  end

  assign conv_irq = done_flag && done_ie && gie;

  // ==================================================================
  // result registers and read lock
  logic rd_lo;
  logic rd_hi;
  assign rd_lo = bus_rd && (haddr == ACC_RES_LO_OFF);
  assign rd_hi = bus_rd && (haddr == ACC_RES_HI_OFF);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      locked <= 1'b0;
    end else if (rd_hi) begin
      locked <= 1'b0;
    end else if (rd_lo) begin
      locked <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= 16'h0000;
    end else if (complete && !locked) begin
      if (chan_latched[ACC_LADJ_BIT]) begin
        result <= {core_result, 6'h00};
      end else begin
        result <= {6'h00, core_result};
      end
    end
  end

  // ==================================================================
  // read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr)
      ACC_CMP_CS_OFF: begin
        next_rdata[ACC_CMP_OUT_BIT] = cmp_s2;
        next_rdata[ACC_CMP_FLAG_BIT] = cmp_flag;
        next_rdata[ACC_CMP_IE_BIT] = cmp_ie;
        next_rdata[ACC_CMP_CAP_BIT] = cmp_cap;
        next_rdata[ACC_CMP_MODE_HI_BIT:ACC_CMP_MODE_LO_BIT] = cmp_mode;
      end
      ACC_SFR_OFF: next_rdata[ACC_SFR_MUXEN_BIT] = mux_en;
      ACC_CONV_CS_OFF: begin
        next_rdata[ACC_CONV_EN_BIT] = conv_en;
        next_rdata[ACC_CONV_START_BIT] = start;
        next_rdata[ACC_CONV_FREE_BIT] = free_run;
        next_rdata[ACC_CONV_DONE_BIT] = done_flag;
        next_rdata[ACC_CONV_DIE_BIT] = done_ie;
      end
      ACC_CHAN_OFF: next_rdata[7:0] = chan_reg;
      ACC_RES_LO_OFF: next_rdata[7:0] = result[7:0];
      ACC_RES_HI_OFF: next_rdata[7:0] = result[15:8];
      ACC_GIE_OFF: next_rdata[0] = gie;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (bus_rd) begin
      hrdata <= next_rdata;
    end
  end

  // ==================================================================
  // checks
  sequence s_locked_done;
    locked && complete;
  endsequence

  chk_irq_gating: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_irq |-> (cmp_ie && gie && cmp_flag)) else $error("cmp irq without enables");
  chk_capture_route: assert property (@(posedge hclk) disable iff (!hresetn)
    !cmp_cap |-> !cmp_capture_out) else $error("capture route leaks");
  chk_rise_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmp_mode == ACC_MODE_RISE && $rose(cmp_s2)) |=> cmp_flag) else $error("rise missed");
  chk_rsvd_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    (cmp_mode == ACC_MODE_RSVD) |=> !$rose(cmp_flag))
    else $error("reserved mode set flag");
  chk_neg_mux: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_en |-> cmp_neg_select == ACC_CMP_MUX_DIS[3:0]) else $error("neg mux while enabled");
  chk_lock_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    s_locked_done |=> $stable(result)) else $error("locked result changed");
  chk_done_lost: assert property (@(posedge hclk) disable iff (!hresetn)
    s_locked_done |=> done_flag) else $error("done flag not set");
  chk_start_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    (complete && !free_run && !conv_cs_wr) |=> !start) else $error("start not cleared");
  chk_cmp_sync: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(cmp_s1) |=> cmp_s2) else $error("sync delay wrong");

endmodule
`default_nettype wire

// >>> tb/acc_front_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// analog front end: comparator level and converter code
module acc_front_model (
  // from the bench
  input wire logic level_in,
  input wire logic [9:0] value_in,
  // from the block
  input wire logic core_sample,
  // to the block
  output logic cmp_raw,
  output logic [9:0] core_result
);
  assign cmp_raw = level_in;
  // code valid only in the sampling cycle, inverted otherwise
  assign core_result = core_sample ? value_in : ~value_in;
endmodule
`default_nettype wire

// >>> tb/adc_and_comparator_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_and_comparator_control_tb;
  import acc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, lvl, ack, cack;
  logic [7:0] haddr;
  logic [1:0] htrans, reference_select;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, d, lo, hi, rnd;
  logic [9:0] val;
  logic [4:0] ch, channel_active;
  logic [3:0] cmp_neg_select;
  logic cmp_raw, cmp_irq, cmp_capture_out, conv_irq, core_enable, core_sample;
  logic [9:0] core_result;
  int n_mismatch, n_compared, m;
  acc_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cmp_raw(cmp_raw), .cmp_irq_ack(ack), .cmp_irq(cmp_irq),
    .cmp_capture_out(cmp_capture_out), .cmp_neg_select(cmp_neg_select),
    .core_result(core_result), .conv_irq_ack(cack), .conv_irq(conv_irq),
    .reference_select(reference_select), .channel_active(channel_active),
    .core_enable(core_enable), .core_sample(core_sample));
  acc_front_model front_u (.level_in(lvl), .value_in(val),
    .core_sample(core_sample), .cmp_raw(cmp_raw), .core_result(core_result));
  // ==========
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [31:0] exp_lo(input logic [9:0] r, input logic la);
    return la ? {24'h0, r[1:0], 6'h0} : {24'h0, r[7:0]};
  endfunction
  function automatic logic [31:0] exp_hi(input logic [9:0] r, input logic la);
    return la ? {24'h0, r[9:2]} : {30'h0, r[9:8]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= w ? wd : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(a, 1'b1, wd, x);
    // one idle edge so outputs fed by the written register have settled
    @(posedge hclk);
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] rd);
    xfer(a, 1'b0, 32'h0, rd);
  endtask
  task automatic wait_done();
    logic [31:0] x;
    int k;
    k = 0;
    rdr(ACC_CONV_CS_OFF, x);
    while (x[4] !== 1'b1 && k < 200) begin
      chk(x[6], 1'b1);
      rdr(ACC_CONV_CS_OFF, x);
      k++;
    end
    chk(x[4], 1'b1);
  endtask
  task automatic settle();
    repeat (4) @(posedge hclk);
  endtask
  task automatic final_report();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========
  // clock, reset, watchdog
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    #200000;
    n_mismatch++;
    final_report();
  end
  // ==========
  // tests
  initial begin
    {hresetn, hsel, hwrite, lvl, ack, cack} = 6'h0;
    haddr = 8'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0;
    val = 10'h0;
    rnd = 32'ha05a;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdr(ACC_CONV_CS_OFF, d);
    chk(d, 32'h0);
    rdr(8'h1c, d);
    chk(d, 32'h0);
    chk(hresp, 1'b0);
    $display("test reset done");
    for (m = 0; m < 4; m++) begin
      wr(ACC_CMP_CS_OFF, 32'h0);
      wr(ACC_CMP_CS_OFF, 32'h10 | m);
      lvl <= 1'b1;
      settle();
      rdr(ACC_CMP_CS_OFF, d);
      chk(d[4], m == 0 || m == 3);
      chk(d[5], 1'b1);
      wr(ACC_CMP_CS_OFF, 32'h10 | m);
      lvl <= 1'b0;
      settle();
      rdr(ACC_CMP_CS_OFF, d);
      chk(d[4], m == 0 || m == 2);
    end
    wr(ACC_GIE_OFF, 32'h1);
    wr(ACC_CMP_CS_OFF, 32'h13);
    chk(cmp_irq, 1'b0);
    wr(ACC_CMP_CS_OFF, 32'h0b);
    lvl <= 1'b1;
    settle();
    chk(cmp_irq, 1'b1);
    ack <= 1'b1;
    @(posedge hclk);
    ack <= 1'b0;
    settle();
    chk(cmp_irq, 1'b0);
    wr(ACC_CMP_CS_OFF, 32'h04);
    settle();
    chk(cmp_capture_out, 1'b1);
    wr(ACC_CMP_CS_OFF, 32'h00);
    settle();
    chk(cmp_capture_out, 1'b0);
    $display("test comparator done");
    rnd = lfsr(rnd);
    ch = rnd[4:0];
    wr(ACC_SFR_OFF, 32'h08);
    wr(ACC_CHAN_OFF, {27'h0, ch});
    chk(cmp_neg_select, {1'b0, ch[2:0]});
    chk(channel_active, 5'h0);
    wr(ACC_CONV_CS_OFF, 32'h88);
    chk(cmp_neg_select, 4'h8);
    rnd = lfsr(rnd);
    val <= rnd[9:0];
    wr(ACC_CONV_CS_OFF, 32'hc8);
    chk(channel_active, ch);
    wait_done();
    rdr(ACC_CONV_CS_OFF, d);
    chk(d[6], 1'b0);
    rdr(ACC_RES_LO_OFF, lo);
    rdr(ACC_RES_HI_OFF, hi);
    chk(lo, exp_lo(val, 1'b0));
    chk(hi, exp_hi(val, 1'b0));
    rdr(ACC_RES_LO_OFF, lo);
    val <= ~val;
    wr(ACC_CONV_CS_OFF, 32'hd8);
    wait_done();
    chk(conv_irq, 1'b1);
    rdr(ACC_RES_HI_OFF, d);
    chk(d, hi);
    rdr(ACC_RES_LO_OFF, d);
    chk(d, lo);
    rdr(ACC_RES_HI_OFF, d);
    rnd = lfsr(rnd);
    val <= rnd[9:0];
    wr(ACC_CHAN_OFF, 32'he0);
    wr(ACC_CONV_CS_OFF, 32'hd8);
    chk(reference_select, 2'b11);
    wr(ACC_CHAN_OFF, 32'he1);
    chk(channel_active, 5'h00);
    wait_done();
    chk(channel_active, 5'h01);
    rdr(ACC_RES_LO_OFF, lo);
    rdr(ACC_RES_HI_OFF, hi);
    chk(lo, exp_lo(val, 1'b1));
    chk(hi, exp_hi(val, 1'b1));
    $display("test single done");
    wr(ACC_CONV_CS_OFF, 32'hf0);
    wait_done();
    val <= ~val;
    // done flag stays set: let two more conversions run on the new code
    repeat (2 * ACC_NORMAL_CYCLES * ACC_CONV_CLK_DIV) @(posedge hclk);
    wait_done();
    rdr(ACC_CONV_CS_OFF, d);
    chk(d[6], 1'b1);
    rdr(ACC_RES_HI_OFF, d);
    chk(d, exp_hi(val, 1'b1));
    wr(ACC_CONV_CS_OFF, 32'h10);
    chk(core_enable, 1'b0);
    $display("test free running done");
    final_report();
  end
endmodule
`default_nettype wire
